// File: hw/gtm_pkg.sv
`default_nettype none
package gtm_pkg;
  // ----------------------------------------
  // configuration and mode encodings
  // ----------------------------------------
  localparam logic [2:0] GTM_CFG_16BIT = 3'h4;
  localparam logic [1:0] GTM_MODE_ONESHOT = 2'h1;
  localparam logic [1:0] GTM_MODE_PERIODIC = 2'h2;
  localparam logic [1:0] GTM_MODE_CAPTURE = 2'h3;
  // event select field
  localparam logic [1:0] GTM_EVT_RISE = 2'h0;
  localparam logic [1:0] GTM_EVT_FALL = 2'h1;
  localparam logic [1:0] GTM_EVT_BOTH = 2'h3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] GTM_LOAD_RST = 16'hFFFF;
  localparam logic [7:0] GTM_PRE_RST = 8'h00;
  localparam logic [15:0] GTM_ZERO = 16'h0000;
  // ----------------------------------------
  // operating kinds derived from mode bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    GTM_K_IDLE,
    GTM_K_ONESHOT,
    GTM_K_PERIODIC,
    GTM_K_ECOUNT,
    GTM_K_ETIME,
    GTM_K_PWM
  } gtm_kind_t;
endpackage : gtm_pkg
`default_nettype wire

// File: hw/gtm_sync.sv
`default_nettype none
module gtm_sync
  import gtm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // asynchronous level in, synchronous level out
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } gtm_sync_t;
  gtm_sync_t st_ff;
  gtm_sync_t nxt_st;

  // first stage feeds only the second
  always_comb begin
    nxt_st.meta = async_in;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.sync;
endmodule : gtm_sync
`default_nettype wire

// File: hw/gtm_half.sv
// What this block does
// - sixteen-bit operation only when configuration is 4
// - one half design, instantiated for A and B
// - down counter, optional prescaler, 24-bit range
// - count from preload, reload after zero
// - one-shot clears enable, periodic keeps running
// - timeout sets sticky raw, masked flag, interrupt
// - trigger pulse on timeout when enabled
// - new load value adopted next cycle
// - freeze during debug halt when stall set
// - prescale p gives p+1 clocks per step
// - prescaler bypassed in capture and pwm
// - capture bit zero selects counting chosen edges
// - each edge decrements, match sets flag
// - after match reload, disable, ignore edges
// - capture bit one selects edge timing
// - edge copies count to capture, sets flag
// - timing counter runs on, reloads at zero
// - pwm when alternate 1, capture 0, mode 2
// - pwm reloads after zero, no flags
// - pwm sets at load, clears at match
// - output level bit inverts pwm
// - mode 1 one-shot, mode 2 periodic
// - mode 3 selects capture operation
// - counter and load reset to ffff, prescale 0
// - writing one to clear bit clears flag
`default_nettype none
module gtm_half
  import gtm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire logic [2:0] timer_configuration_reg,
  input wire logic [1:0] half_timer_mode_field,
  input wire logic capture_mode_bit,
  input wire logic alternate_mode_select_bit,
  input wire logic [1:0] event_select,
  input wire logic output_trigger_enable_bit,
  input wire logic debug_stall_bit,
  input wire logic pwm_output_level_bit,
  input wire logic debug_halted,
  // enable control: set pulse from software, level mirrors hardware clear
  input wire logic enable_set,
  input wire logic enable_clr,
  // load values, write strobes
  input wire logic [15:0] load_wdata,
  input wire logic load_we,
  input wire logic [7:0] prescale_wdata,
  input wire logic prescale_we,
  input wire logic [15:0] half_match_reg,
  // interrupt mask and clear (timeout, match, event)
  input wire logic [2:0] interrupt_mask_reg,
  input wire logic [2:0] interrupt_clear_reg,
  // capture/compare pin
  input wire logic capture_compare_pin_in,
  output logic capture_compare_pin_out,
  output logic capture_compare_pin_oe,
  // status
  output logic half_enable_bit,
  output logic [15:0] half_count_capture_reg,
  output logic [15:0] counter_value,
  output logic [15:0] half_interval_load_reg,
  output logic [7:0] half_prescale_reg,
  output logic [2:0] raw_interrupt_status_reg,
  output logic [2:0] masked_interrupt_status_reg,
  output logic interrupt_out,
  output logic adc_trigger
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic [15:0] cnt;
    logic [7:0] pcnt;
    logic [15:0] load;
    logic [7:0] pre;
    logic [15:0] cap;
    logic [2:0] raw;
    logic [2:0] mis;
    logic irq;
    logic trig;
    logic pin_prev;
    logic pwm;
    logic pwm_out;
    logic pwm_oe;
  } gtm_half_t;
  gtm_half_t st_ff;
  gtm_half_t nxt_st;

  logic pin_sync;
  gtm_kind_t kind;
  logic edge_hit;
  logic run;
  logic step;

  // pin synchroniser
  gtm_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(capture_compare_pin_in),
    .sync_out(pin_sync)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  function automatic gtm_kind_t decode_kind(input logic [2:0] cfg, input logic [1:0] mode,
                                            input logic cmr, input logic ams);
    gtm_kind_t k;
    k = GTM_K_IDLE;
    if (cfg == GTM_CFG_16BIT) begin
      if (ams && !cmr && mode == GTM_MODE_PERIODIC) begin
        k = GTM_K_PWM;
      end else if (mode == GTM_MODE_ONESHOT) begin
        k = GTM_K_ONESHOT;
      end else if (mode == GTM_MODE_PERIODIC) begin
        k = GTM_K_PERIODIC;
      end else if (mode == GTM_MODE_CAPTURE) begin
        k = cmr ? GTM_K_ETIME : GTM_K_ECOUNT;
      end
    end
    return k;
  endfunction : decode_kind

  // selected edge on the synchronised pin
  function automatic logic edge_match(input logic [1:0] sel, input logic prev, input logic cur);
    logic r;
    r = 1'b0;
    unique case (sel)
      GTM_EVT_RISE: r = !prev && cur;
      GTM_EVT_FALL: r = prev && !cur;
      GTM_EVT_BOTH: r = prev != cur;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : edge_match

  assign kind = decode_kind(timer_configuration_reg, half_timer_mode_field,
                            capture_mode_bit, alternate_mode_select_bit);
  assign edge_hit = edge_match(event_select, st_ff.pin_prev, pin_sync);
  assign run = st_ff.en && !(debug_stall_bit && debug_halted);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.trig = 1'b0;
    nxt_st.pin_prev = pin_sync;
    step = 1'b0;
    // clears first, so hardware sets below win
    nxt_st.raw = st_ff.raw & ~interrupt_clear_reg;
    if (enable_set) begin
      nxt_st.en = 1'b1;
    end else if (enable_clr) begin
      nxt_st.en = 1'b0;
    end
    if (prescale_we) begin
      nxt_st.pre = prescale_wdata;
    end
    if (load_we) begin
      nxt_st.load = load_wdata;
      nxt_st.cnt = load_wdata;
      nxt_st.pcnt = (prescale_we) ? prescale_wdata : st_ff.pre;
    end else if (run) begin
      unique case (kind)
        GTM_K_ONESHOT, GTM_K_PERIODIC: begin
          // prescaler stretches each step to pre+1 clocks
          if (st_ff.pcnt == GTM_PRE_RST) begin
            step = 1'b1;
          end else begin
            nxt_st.pcnt = st_ff.pcnt - 8'h01;
          end
          if (step) begin
            if (st_ff.cnt == GTM_ZERO) begin
              nxt_st.cnt = st_ff.load;
              nxt_st.pcnt = st_ff.pre;
              nxt_st.raw[0] = 1'b1;
              nxt_st.trig = output_trigger_enable_bit;
              if (kind == GTM_K_ONESHOT) begin
                nxt_st.en = 1'b0;
              end
            end else begin
              nxt_st.cnt = st_ff.cnt - 16'h0001;
              nxt_st.pcnt = st_ff.pre;
            end
          end
        end
        GTM_K_ECOUNT: begin
          // no prescaler here
          if (st_ff.cnt == half_match_reg) begin
            nxt_st.raw[1] = 1'b1;
            nxt_st.cnt = st_ff.load;
            nxt_st.en = 1'b0;
          end else if (edge_hit) begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
          end
        end
        GTM_K_ETIME: begin
          if (edge_hit) begin
            nxt_st.cap = st_ff.cnt;
            nxt_st.raw[2] = 1'b1;
          end
          nxt_st.cnt = (st_ff.cnt == GTM_ZERO) ? st_ff.load : st_ff.cnt - 16'h0001;
        end
        GTM_K_PWM: begin
          nxt_st.cnt = (st_ff.cnt == GTM_ZERO) ? st_ff.load : st_ff.cnt - 16'h0001;
        end
        default: begin
        end
      endcase
    end
    // pwm waveform from the count value, no flags in this mode
    if (kind == GTM_K_PWM) begin
      if (st_ff.cnt == st_ff.load) begin
        nxt_st.pwm = 1'b1;
      end else if (st_ff.cnt == half_match_reg) begin
        nxt_st.pwm = 1'b0;
      end
      nxt_st.pwm_oe = st_ff.en;
    end else begin
      nxt_st.pwm = 1'b0;
      nxt_st.pwm_oe = 1'b0;
    end
    nxt_st.pwm_out = nxt_st.pwm ^ pwm_output_level_bit;
    nxt_st.mis = nxt_st.raw & interrupt_mask_reg;
    nxt_st.irq = |nxt_st.mis;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.cnt <= GTM_LOAD_RST;
      st_ff.load <= GTM_LOAD_RST;
      st_ff.pre <= GTM_PRE_RST;
      st_ff.pcnt <= GTM_PRE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign half_enable_bit = st_ff.en;
  assign half_count_capture_reg = st_ff.cap;
  assign counter_value = st_ff.cnt;
  assign half_interval_load_reg = st_ff.load;
  assign half_prescale_reg = st_ff.pre;
  assign raw_interrupt_status_reg = st_ff.raw;
  assign masked_interrupt_status_reg = st_ff.mis;
  assign interrupt_out = st_ff.irq;
  assign adc_trigger = st_ff.trig;
  assign capture_compare_pin_out = st_ff.pwm_out;
  assign capture_compare_pin_oe = st_ff.pwm_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reload_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (run && !load_we && kind == GTM_K_PERIODIC && st_ff.cnt == GTM_ZERO
     && st_ff.pcnt == GTM_PRE_RST) |=> (st_ff.cnt == $past(st_ff.load)))
    else $error("counter did not reload after zero");
  a_oneshot_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (run && !load_we && !enable_set && kind == GTM_K_ONESHOT && st_ff.cnt == GTM_ZERO
     && st_ff.pcnt == GTM_PRE_RST) |=> !st_ff.en)
    else $error("one-shot kept its enable");
  a_timeout_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (run && !load_we && (kind == GTM_K_ONESHOT || kind == GTM_K_PERIODIC)
     && st_ff.cnt == GTM_ZERO && st_ff.pcnt == GTM_PRE_RST) |=> st_ff.raw[0])
    else $error("timeout flag not set");
  a_trig_gate: assert property (@(posedge ref_clk) disable iff (rst)
    st_ff.trig |-> $past(output_trigger_enable_bit))
    else $error("trigger without enable");
  a_load_adopt: assert property (@(posedge ref_clk) disable iff (rst)
    load_we |=> (st_ff.cnt == $past(load_wdata)))
    else $error("load value not adopted");
  a_stall_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (debug_stall_bit && debug_halted && !load_we) |=> $stable(st_ff.cnt))
    else $error("counter moved while stalled");
  a_prescale_step: assert property (@(posedge ref_clk) disable iff (rst)
    (run && !load_we && kind == GTM_K_PERIODIC && st_ff.pcnt != GTM_PRE_RST)
    |=> $stable(st_ff.cnt))
    else $error("counter stepped before prescale ran out");
  a_ecount_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (run && !load_we && !enable_set && kind == GTM_K_ECOUNT && st_ff.cnt == half_match_reg)
    |=> (!st_ff.en && st_ff.raw[1]))
    else $error("edge count did not stop on match");
  a_capture_copy: assert property (@(posedge ref_clk) disable iff (rst)
    (run && !load_we && kind == GTM_K_ETIME && edge_hit) |=> (st_ff.cap == $past(st_ff.cnt)))
    else $error("capture register missed the count");
endmodule : gtm_half
`default_nettype wire

// File: tb/gtm_src.sv
`default_nettype none
// ----------------------------------------
// edge source on the capture pin
// ----------------------------------------
module gtm_src (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // command from the bench
  input wire logic go,
  input wire logic [7:0] n_ed,
  input wire logic [7:0] gap,
  // pin level and status
  output logic lvl,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  logic [7:0] hold_ff;
  // toggles n_ed times, each level held gap clocks and never under two
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lvl <= 1'b0;
      left_ff <= 8'h00;
      hold_ff <= 8'h00;
    end else if (go) begin
      left_ff <= n_ed;
      hold_ff <= 8'h00;
    end else if (hold_ff != 8'h00) begin
      hold_ff <= hold_ff - 8'h01;
    end else if (left_ff != 8'h00) begin
      lvl <= ~lvl;
      left_ff <= left_ff - 8'h01;
      hold_ff <= (gap < 8'h02) ? 8'h01 : gap - 8'h01;
    end
  end
  // busy until the last level has been held
  assign busy = (left_ff != 8'h00) || (hold_ff != 8'h00);
endmodule : gtm_src
`default_nettype wire

// File: tb/gtm_half_test.sv
`default_nettype none
// ----------------------------------------
// bench for one timer half
// ----------------------------------------
module gtm_half_test
  import gtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, cmr, ams, ote, stall, pwml, halt, en_s, en_c, ld_we, pre_we, go;
  logic [2:0] cfg, imask, iclr, raw, mis;
  logic [1:0] mode, evt;
  logic [15:0] ld, match, cap, cnt, v, ilr;
  logic [7:0] pre, preg, n_ed, gap;
  logic pout, oe, en, irq, trig, src_lvl, busy;
  wire logic pin;
  int n_errors, num_checks, cyc, i, k;
  // pin level from both drivers
  assign pin = oe ? pout : src_lvl;
  gtm_half gtm_half_inst (
    .ref_clk(ref_clk), .rst(rst), .timer_configuration_reg(cfg),
    .half_timer_mode_field(mode), .capture_mode_bit(cmr), .alternate_mode_select_bit(ams),
    .event_select(evt), .output_trigger_enable_bit(ote), .debug_stall_bit(stall),
    .pwm_output_level_bit(pwml), .debug_halted(halt), .enable_set(en_s), .enable_clr(en_c),
    .load_wdata(ld), .load_we(ld_we), .prescale_wdata(pre), .prescale_we(pre_we),
    .half_match_reg(match), .interrupt_mask_reg(imask), .interrupt_clear_reg(iclr),
    .capture_compare_pin_in(pin), .capture_compare_pin_out(pout),
    .capture_compare_pin_oe(oe), .half_enable_bit(en), .half_count_capture_reg(cap),
    .counter_value(cnt), .half_interval_load_reg(ilr), .half_prescale_reg(preg),
    .raw_interrupt_status_reg(raw), .masked_interrupt_status_reg(mis),
    .interrupt_out(irq), .adc_trigger(trig));
  gtm_src gtm_src_inst (.ref_clk(ref_clk), .rst(rst), .go(go), .n_ed(n_ed), .gap(gap),
    .lvl(src_lvl), .busy(busy));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  task automatic start(input logic [1:0] md, input logic [15:0] l, input logic [7:0] p);
    mode = md;
    ld = l;
    pre = p;
    {ld_we, pre_we} = 2'h3;
    tick(1);
    {ld_we, pre_we} = 2'h0;
    en_s = 1'b1;
    tick(1);
    en_s = 1'b0;
    tick(1);
  endtask : start
  task automatic halt_half(input string s);
    en_c = 1'b1;
    tick(1);
    en_c = 1'b0;
    iclr = 3'h7;
    tick(1);
    iclr = 3'h0;
    tick(2);
    $display("test %s finished", s);
  endtask : halt_half
  task automatic edges(input logic [7:0] n, input logic [7:0] g);
    n_ed = n;
    gap = g;
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask : edges
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    check(cnt, 16'hFFFF);
    check(ilr, 16'hFFFF);
    check({8'h00, preg}, 16'h0000);
    check({13'h0, raw}, 16'h0000);
    cfg = 3'h0;
    start(GTM_MODE_PERIODIC, 16'hFFFF, 8'h00);
    tick(4);
    check(cnt, 16'hFFFF);
    cfg = GTM_CFG_16BIT;
    halt_half("reset");
  endtask : t_reset
  task automatic t_oneshot;
    imask = 3'h1;
    start(GTM_MODE_ONESHOT, 16'h0002, 8'h00);
    for (i = 0; i < 20 && en !== 1'b0; i++) tick(1);
    tick(1);
    check({15'h0, raw[0]}, 16'h0001);
    check({14'h0, mis[0], irq}, 16'h0003);
    check(cnt, 16'h0002);
    tick(5);
    check({15'h0, en}, 16'h0000);
    check(cnt, 16'h0002);
    halt_half("oneshot");
  endtask : t_oneshot
  task automatic t_periodic;
    ote = 1'b1;
    start(GTM_MODE_PERIODIC, 16'h0002, 8'h03);
    check({8'h00, preg}, 16'h0003);
    for (i = 0; i < 60 && trig !== 1'b1; i++) tick(1);
    iclr = 3'h1;
    tick(1);
    iclr = 3'h0;
    check({15'h0, raw[0]}, 16'h0000);
    for (k = 1; k < 40 && trig !== 1'b1; k++) tick(1);
    check(16'(k), 16'd12);
    check({15'h0, raw[0]}, 16'h0001);
    ld = 16'h0007;
    ld_we = 1'b1;
    tick(1);
    ld_we = 1'b0;
    check(cnt, 16'h0007);
    check(ilr, 16'h0007);
    {stall, halt} = 2'h3;
    v = cnt;
    tick(8);
    check(cnt, v);
    halt = 1'b0;
    tick(8);
    check({15'h0, cnt == v}, 16'h0000);
    {stall, ote, k} = '0;
    for (i = 0; i < 40; i++) begin
      tick(1);
      if (trig !== 1'b0) k++;
    end
    check(16'(k), 16'h0000);
    halt_half("periodic");
  endtask : t_periodic
  task automatic t_ecount;
    {cmr, imask, match} = {1'b0, 3'h2, 16'h0006};
    for (int e = 0; e < 3; e++) begin
      evt = (e == 2) ? GTM_EVT_BOTH : 2'(e);
      start(GTM_MODE_CAPTURE, 16'h000A, 8'h00);
      edges((e == 2) ? 8'd6 : 8'd8, 8'd3);
      for (i = 0; i < 90 && busy !== 1'b0; i++) tick(1);
      tick(5);
      check({14'h0, raw[1], mis[1]}, 16'h0003);
      check({15'h0, en}, 16'h0000);
      check(cnt, 16'h000A);
      halt_half("edge count");
    end
    // event select 2 picks no edge at all
    evt = 2'h2;
    start(GTM_MODE_CAPTURE, 16'h000A, 8'h00);
    edges(8'd4, 8'd3);
    for (i = 0; i < 90 && busy !== 1'b0; i++) tick(1);
    tick(5);
    check(cnt, 16'h000A);
    check({15'h0, raw[1]}, 16'h0000);
    halt_half("no edge");
  endtask : t_ecount
  task automatic t_etime;
    {cmr, evt, imask} = {1'b1, GTM_EVT_RISE, 3'h4};
    start(GTM_MODE_CAPTURE, 16'hFFFF, 8'h00);
    edges(8'd4, 8'd5);
    for (i = 0; i < 40 && raw[2] !== 1'b1; i++) tick(1);
    v = cap;
    iclr = 3'h4;
    tick(1);
    iclr = 3'h0;
    for (i = 0; i < 40 && raw[2] !== 1'b1; i++) tick(1);
    tick(1);
    check(v - cap, 16'd10);
    check({15'h0, mis[2]}, 16'h0001);
    check({15'h0, en}, 16'h0001);
    tick(12);
    halt_half("edge time");
  endtask : t_etime
  task automatic t_pwm(input logic l);
    {cmr, ams, pwml, imask, match} = {2'b01, l, 3'h7, 16'h0003};
    start(GTM_MODE_PERIODIC, 16'h0009, 8'h05);
    tick(20);
    k = 0;
    for (i = 0; i < 10; i++) begin
      tick(1);
      if (pin === 1'b1) k++;
    end
    check(16'(k), l ? 16'd4 : 16'd6);
    check({15'h0, oe}, 16'h0001);
    check({13'h0, raw}, 16'h0000);
    halt_half("pwm");
    {ams, pwml} = 2'h0;
  endtask : t_pwm
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  always #4 ref_clk = ~ref_clk;
  // cuts a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      stop_test;
    end
  end
  // reset, then the scenarios in turn
  initial begin
    {ref_clk, rst, cmr, ams, ote, stall, pwml, halt, en_s, en_c, ld_we, pre_we, go} = 13'h0800;
    {cfg, imask, iclr, mode, evt, ld, match, pre, n_ed, gap} = {GTM_CFG_16BIT, 66'h0};
    {n_errors, num_checks, cyc} = '0;
    tick(5);
    rst = 1'b0;
    t_reset;
    t_oneshot;
    t_periodic;
    t_ecount;
    t_etime;
    t_pwm(1'b0);
    t_pwm(1'b1);
    stop_test;
  end
endmodule : gtm_half_test
`default_nettype wire
